/* pkg/slcs_regs.svh */
/*
 * Offsets, field positions, reset values and fixed codes of the serial
 * link configuration and status bank.
 * Assumes it is included by bare name from the design and the bench.
 */
`ifndef SLCS_REGS_SVH
`define SLCS_REGS_SVH

// ==========================================================================
// Register indices; the byte address on the bus is four times the index.
`define SLCS_IDX_DEVICE_ID   12'h206
`define SLCS_IDX_COMMA_SEL   12'h207
`define SLCS_IDX_STATUS      12'h208
`define SLCS_IDX_CHAN_EN     12'h209
`define SLCS_IDX_IRQ_MASK    12'h20A
`define SLCS_IDX_LINK_CTRL   12'h20B

// ==========================================================================
// Reset values.
`define SLCS_RST_DEVICE_ID   8'h00
`define SLCS_RST_COMMA_SEL   2'h0
`define SLCS_RST_CHAN_EN     3'h3
`define SLCS_RST_IRQ_MASK    8'h00
`define SLCS_RST_LINK_CTRL   2'h0

// ==========================================================================
// Field positions.
`define SLCS_ST_LINK_UP      6
`define SLCS_ST_SYNC         5
`define SLCS_ST_REALIGNED    4
`define SLCS_ST_PHASE_SET    3
`define SLCS_ST_SER_PLL      2
`define SLCS_ST_SMP_PLL      0
`define SLCS_CH_ONE_CHAN     2
`define SLCS_CH_UPPER        1
`define SLCS_CH_LOWER        0
`define SLCS_CTRL_LINK_EN    0
`define SLCS_CTRL_ENC_64B    1

// ==========================================================================
// End-of-frame control characters, 8-bit values with the K flag set.
`define SLCS_K28_7           8'hFC
`define SLCS_K28_1           8'h3C
`define SLCS_K28_5           8'hBC

`endif

/* pkg/slcs_pkg.sv */
/*
 * Types shared by the serial link configuration and status bank.
 */
package slcs_pkg;

   // =======================================================================
   // Basic data types.
   typedef logic [7:0]  slcs_byte_t;
   typedef logic [11:0] slcs_idx_t;
   typedef logic [3:0]  slcs_count_t;

   // =======================================================================
   // Bus data phase tracking, one-hot.
   typedef enum logic [2:0] {
      SLCS_PH_IDLE  = 3'b001,
      SLCS_PH_WRITE = 3'b010,
      SLCS_PH_READ  = 3'b100
   } slcs_phase_e;

endpackage : slcs_pkg

/* hw/slcs_bank.sv */
/*
 * Configuration and status register bank of a multi-lane serial output
 * link, an AHB-Lite slave with zero wait states and an OKAY-only answer.
 * Assumes every input is synchronous to hclk, that hclk_en is high while
 * a bus transfer is in progress, and that transfers are single words.
 */
// Contract
// - Device id sent in second ILA multiframe.
// - Comma select: 0 K28.7, 1 K28.1, 2 K28.5.
// - Status bit 6 shows link up.
// - Status bit 5 shows SYNC~ level.
// - Bit 4 sticky realign flag, write-one clears.
// - Bit 3 set by first SYSREF after enable.
// - Status bit 2 shows serializer PLL lock.
// - Bit 0 sampling PLL lock; 7,1 reserved.
// - Channel enable resets 0x03, three fields.
// - One-channel mode leaves only first channel.
// - Half pair: half converters, ceiling half lanes.
`timescale 1ns/10ps
`include "slcs_regs.svh"

module slcs_bank (
   input  wire  logic                hclk,
   input  wire  logic                hresetn,
   input  wire  logic                hclk_en,
   input  wire  logic                hsel,
   input  wire  logic [31:0]         haddr,
   input  wire  logic [1:0]          htrans,
   input  wire  logic                hwrite,
   input  wire  logic [2:0]          hsize,
   input  wire  logic [31:0]         hwdata,
   input  wire  logic                hready,
   output logic                      hreadyout,
   output logic [31:0]               hrdata,
   output logic                      hresp,
   input  wire  logic                link_up,
   input  wire  logic                sync_n,
   input  wire  logic                serializer_pll_lock,
   input  wire  logic                sampling_pll_lock,
   input  wire  logic                sysref_realign,
   input  wire  logic                sysref_event,
   input  wire  logic                ila_second_mf,
   input  wire  logic                frame_end_slot,
   input  wire  slcs_pkg::slcs_count_t lanes_full,
   input  wire  slcs_pkg::slcs_count_t conv_full,
   output logic                      link_enable,
   output logic                      enc_64b66b,
   output slcs_pkg::slcs_byte_t      ila_octet,
   output slcs_pkg::slcs_byte_t      eof_comma,
   output logic                      eof_comma_insert,
   output logic [3:0]                chan_active,
   output slcs_pkg::slcs_count_t     lanes_used,
   output slcs_pkg::slcs_count_t     conv_used,
   output logic                      tail_pad,
   output logic                      irq
);
   import slcs_pkg::*;

   // ======================================================================
   // Storage.
   slcs_byte_t  did_reg;
   logic [1:0]  comma_sel_reg;
   logic [2:0]  chan_en_reg;
   slcs_byte_t  irq_mask_reg;
   logic [1:0]  flag_reg;       // [1] realigned, [0] phase set.
   logic [1:0]  flag_set;
   logic        phase_armed_reg;
   slcs_phase_e phase_reg;
   slcs_idx_t   wr_idx_reg;
   slcs_byte_t  rd_value;
   slcs_byte_t  status_value;
   logic        addr_phase;
   logic        wr_take;

   // True when a byte address selects the word of the given index.
   function automatic logic reg_hit(input logic [31:0] addr, input slcs_idx_t idx);
      reg_hit = (addr[31:14] == 18'h0_0000) && (addr[13:2] == idx);
   endfunction : reg_hit

   // True when a write in its data phase targets the given index.
   function automatic logic wr_hit(input logic take, input slcs_idx_t at, input slcs_idx_t idx);
      wr_hit = take && (at == idx);
   endfunction : wr_hit

   // ======================================================================
   // Bus slave.
   // A new transfer is taken only when hready shows the previous one done.
   assign addr_phase = hsel && htrans[1] && hready;
   assign wr_take    = (phase_reg == SLCS_PH_WRITE) && hclk_en;

   // Address phase capture; the data phase is always a single cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_reg  <= SLCS_PH_IDLE;
         wr_idx_reg <= 12'h000;
      end else if (hclk_en) begin
         case (phase_reg)
            SLCS_PH_IDLE, SLCS_PH_WRITE, SLCS_PH_READ: begin
               if (!addr_phase) begin
                  phase_reg <= SLCS_PH_IDLE;
               end else begin
                  phase_reg <= hwrite ? SLCS_PH_WRITE : SLCS_PH_READ;
               end
               wr_idx_reg <= (haddr[31:14] == 18'h0_0000) ? haddr[13:2] : 12'hFFF;
            end
            default: begin
               phase_reg <= SLCS_PH_IDLE;
            end
         endcase
      end
   end

   // Live status is composed on the fly and never stored.
   // live bits ignore writes
   always_comb begin
      status_value = 8'h00;
      status_value[`SLCS_ST_LINK_UP]   = link_up;
      status_value[`SLCS_ST_SYNC]      = sync_n;
      status_value[`SLCS_ST_REALIGNED] = flag_reg[1];
      status_value[`SLCS_ST_PHASE_SET] = flag_reg[0];
      status_value[`SLCS_ST_SER_PLL]   = serializer_pll_lock;
      status_value[`SLCS_ST_SMP_PLL]   = sampling_pll_lock;
   end

   // Read multiplexer; unmapped words read as zero.
   always_comb begin
      rd_value = 8'h00;
      if (reg_hit(haddr, `SLCS_IDX_DEVICE_ID)) begin
         rd_value = did_reg;
      end else if (reg_hit(haddr, `SLCS_IDX_COMMA_SEL)) begin
         rd_value = {6'h00, comma_sel_reg};
      end else if (reg_hit(haddr, `SLCS_IDX_STATUS)) begin
         rd_value = status_value;
      end else if (reg_hit(haddr, `SLCS_IDX_CHAN_EN)) begin
         rd_value = {5'h00, chan_en_reg};
      end else if (reg_hit(haddr, `SLCS_IDX_IRQ_MASK)) begin
         rd_value = irq_mask_reg;
      end else if (reg_hit(haddr, `SLCS_IDX_LINK_CTRL)) begin
         rd_value = {6'h00, enc_64b66b, link_enable};
      end
   end

   // Zero wait states and OKAY only; read data is fetched at the address
   // phase so it stands in the data phase. A read right after a write would
   // see stale data, so the master must leave an idle cycle between them.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else if (hclk_en) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addr_phase && !hwrite) begin
            hrdata <= {24'h00_0000, rd_value};
         end
      end
   end

   // ======================================================================
   // Software-written configuration.
   // Reserved bits are not stored, so they read back as zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         did_reg       <= `SLCS_RST_DEVICE_ID;
         comma_sel_reg <= `SLCS_RST_COMMA_SEL;
         chan_en_reg   <= `SLCS_RST_CHAN_EN;
         irq_mask_reg  <= `SLCS_RST_IRQ_MASK;
         {enc_64b66b, link_enable} <= `SLCS_RST_LINK_CTRL;
      end else begin
         if (wr_hit(wr_take, wr_idx_reg, `SLCS_IDX_DEVICE_ID)) begin
            did_reg <= hwdata[7:0];
         end
         if (wr_hit(wr_take, wr_idx_reg, `SLCS_IDX_COMMA_SEL)) begin
            comma_sel_reg <= hwdata[1:0];
         end
         if (wr_hit(wr_take, wr_idx_reg, `SLCS_IDX_CHAN_EN)) begin
            chan_en_reg <= hwdata[2:0];
         end
         if (wr_hit(wr_take, wr_idx_reg, `SLCS_IDX_IRQ_MASK)) begin
            irq_mask_reg <= hwdata[7:0];
         end
         if (wr_hit(wr_take, wr_idx_reg, `SLCS_IDX_LINK_CTRL)) begin
            link_enable <= hwdata[`SLCS_CTRL_LINK_EN];
            enc_64b66b  <= hwdata[`SLCS_CTRL_ENC_64B];
         end
      end
   end

   // ======================================================================
   // Sticky SYSREF event flags.
   // first SYSREF arming
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_armed_reg <= 1'b0;
      end else if (hclk_en) begin
         if (wr_hit(wr_take, wr_idx_reg, `SLCS_IDX_LINK_CTRL) &&
             hwdata[`SLCS_CTRL_LINK_EN] && !link_enable) begin
            phase_armed_reg <= 1'b1;
         end else if (sysref_event) begin
            phase_armed_reg <= 1'b0;
         end
      end
   end

   assign flag_set = {sysref_realign, sysref_event && phase_armed_reg};

   // Write one clears; a set in the same cycle wins, and the live bits of
   // the status word simply have no storage for a write to land in.
   generate
      for (genvar i = 0; i < 2; i++) begin : g_flag
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               flag_reg[i] <= 1'b0;
            end else if (hclk_en) begin
               if (flag_set[i]) begin
                  flag_reg[i] <= 1'b1;
               end else if (wr_hit(wr_take, wr_idx_reg, `SLCS_IDX_STATUS) &&
                            hwdata[`SLCS_ST_PHASE_SET + i]) begin
                  flag_reg[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Interrupt is a level while any unmasked flag stands.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else if (hclk_en) begin
         irq <= |({flag_reg, 3'b000} & irq_mask_reg[4:0]);
      end
   end

   // ======================================================================
   // Link-facing outputs.
   // identifier and comma
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ila_octet        <= 8'h00;
         eof_comma        <= `SLCS_K28_7;
         eof_comma_insert <= 1'b0;
      end else if (hclk_en) begin
         ila_octet        <= ila_second_mf ? did_reg : 8'h00;
         // Reserved select 3 falls back to the default character.
         case (comma_sel_reg)
            2'h1:    eof_comma <= `SLCS_K28_1;
            2'h2:    eof_comma <= `SLCS_K28_5;
            default: eof_comma <= `SLCS_K28_7;
         endcase
         eof_comma_insert <= frame_end_slot && link_enable && !enc_64b66b;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan_active <= 4'hF;
         lanes_used  <= 4'h0;
         conv_used   <= 4'h0;
         tail_pad    <= 1'b0;
      end else if (hclk_en) begin
         chan_active <= chan_en_reg[`SLCS_CH_ONE_CHAN] ? 4'h1 :
                        {{2{chan_en_reg[`SLCS_CH_UPPER]}}, {2{chan_en_reg[`SLCS_CH_LOWER]}}};
         if (chan_en_reg[`SLCS_CH_UPPER] ^ chan_en_reg[`SLCS_CH_LOWER]) begin
            lanes_used <= 4'((5'(lanes_full) + 5'h01) >> 1);
            conv_used  <= conv_full >> 1;
            tail_pad   <= lanes_full[0];
         end else begin
            lanes_used <= lanes_full;
            conv_used  <= conv_full;
            tail_pad   <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Checks; all of them share the bus clock and the bus reset.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_ila_did_out: assert property (hclk_en && ila_second_mf |=> ila_octet == $past(did_reg))
      else $error("ILA octet does not carry device identifier.");
   chk_comma_code_map: assert property (hclk_en && comma_sel_reg == 2'h2 |=> eof_comma == 8'hBC)
      else $error("Select two did not give K28.5.");
   chk_comma_64b_off: assert property (enc_64b66b && hclk_en |=> !eof_comma_insert)
      else $error("Comma inserted in 64B/66B mode.");
   chk_link_up_read: assert property (hclk_en && addr_phase && !hwrite &&
      reg_hit(haddr, `SLCS_IDX_STATUS) |=> hrdata[6] == $past(link_up))
      else $error("Status bit 6 does not follow link up.");
   chk_sync_read: assert property (hclk_en && addr_phase && !hwrite &&
      reg_hit(haddr, `SLCS_IDX_STATUS) |=> hrdata[5] == $past(sync_n))
      else $error("Status bit 5 does not follow SYNC~.");
   chk_realign_stick: assert property (hclk_en && sysref_realign |=> flag_reg[1])
      else $error("Realign flag not set by SYSREF.");
   chk_phase_first: assert property (hclk_en && sysref_event && !phase_armed_reg &&
      !flag_reg[0] |=> !flag_reg[0])
      else $error("Phase flag set without arming.");
   chk_pll_read: assert property (hclk_en && addr_phase && !hwrite &&
      reg_hit(haddr, `SLCS_IDX_STATUS) |=> hrdata[2] == $past(serializer_pll_lock) &&
      hrdata[0] == $past(sampling_pll_lock) && hrdata[7] == 1'b0)
      else $error("PLL lock bits wrong in status.");
   chk_one_channel: assert property (hclk_en && chan_en_reg[2] |=> chan_active == 4'h1)
      else $error("One-channel mode left extra channels on.");
   chk_lane_half: assert property (hclk_en && (chan_en_reg[1] ^ chan_en_reg[0]) |=>
      lanes_used == 4'((5'($past(lanes_full)) + 5'h01) >> 1) &&
      tail_pad == $past(lanes_full[0]))
      else $error("Lane count not halved with tail padding.");
   chk_set_wins: assert property (hclk_en && flag_set[1] && wr_take |=> flag_reg[1])
      else $error("Clear beat a simultaneous realign event.");
   // Interrupt follows an unmasked flag one cycle later.
   chk_irq_level: assert property (hclk_en && flag_reg[1] && irq_mask_reg[4] |=> irq)
      else $error("Interrupt missing for unmasked flag.");

   cov_flag_clear: cover property (flag_reg[1] ##1 !flag_reg[1]);
   cov_phase_set:  cover property (phase_armed_reg && sysref_event && hclk_en);
   cov_comma_out:  cover property (eof_comma_insert && eof_comma == 8'h3C);
   cov_irq_rise:   cover property ($rose(irq));

endmodule : slcs_bank

/* verification/slcs_bank_tb_top.sv */
/*
 * Self-checking bench for the serial link configuration and status bank.
 * Assumes the bank is the only slave on its AHB-Lite bus, that it answers
 * with zero wait states, and that the constants header is on the include path.
 */
`timescale 1ns/10ps
`include "slcs_regs.svh"

module slcs_bank_tb_top;
   import slcs_pkg::*;

   typedef struct {
      string       name;
      logic [31:0] exp;
   } slcs_note_s;

   // ======================================================================
   // Signals.
   logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dp;
   logic [31:0]      haddr, hwdata, hrdata;
   logic [1:0]       htrans;
   logic             link_up, sync_n, ser_lock, smp_lock, realign, sysref;
   logic             ila_mf, fes, link_enable, enc_64b66b, ins, tail_pad, irq, ce;
   slcs_count_t      lanes_full, conv_full, lanes_used, conv_used;
   slcs_byte_t       ila_octet, eof_comma;
   logic [3:0]       chan_active;
   int               n_errors, checks, lf, mf;
   logic [31:0]      r;
   logic [7:0]       v, half, ca;
   slcs_note_s       notes[$];
   slcs_note_s       cur;
   logic [7:0]       commas[4] = '{`SLCS_K28_7, `SLCS_K28_1, `SLCS_K28_5, `SLCS_K28_7};
   logic [7:0]       chans[4]  = '{8'h03, 8'h01, 8'h02, 8'h05};

   // Clock enable drops only between transfers: a low enable mid-transfer is unsupported.
   slcs_bank dut (.hclk(hclk), .hresetn(hresetn), .hclk_en(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .link_up(link_up), .sync_n(sync_n), .serializer_pll_lock(ser_lock),
      .sampling_pll_lock(smp_lock), .sysref_realign(realign), .sysref_event(sysref),
      .ila_second_mf(ila_mf), .frame_end_slot(fes), .lanes_full(lanes_full),
      .conv_full(conv_full), .link_enable(link_enable), .enc_64b66b(enc_64b66b),
      .ila_octet(ila_octet), .eof_comma(eof_comma), .eof_comma_insert(ins),
      .chan_active(chan_active), .lanes_used(lanes_used), .conv_used(conv_used),
      .tail_pad(tail_pad), .irq(irq));

   // ======================================================================
   // Compare and report tasks.
   task automatic cmp_rd(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_rd

   task automatic cmp_port(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_port

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   // ======================================================================
   // Bus master tasks; the master never assumes a latency, it waits for hready.
   function automatic logic [31:0] adr(input slcs_idx_t i);
      return {18'h0_0000, i, 2'b00};
   endfunction : adr

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         $display("[FAIL] hready expected 1 seen %b", hreadyout);
         summarize();
      end
   endtask : wait_rdy

   // A leading edge gives one idle cycle, so a read never follows a write directly.
   task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d,
                      input logic pr);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      hsel    <= 1'b0;
      htrans  <= 2'b00;
      hwdata  <= {24'h00_0000, d};
      realign <= pr;
      wait_rdy();
      realign <= 1'b0;
   endtask : bus

   task automatic wr(input slcs_idx_t i, input logic [7:0] d, input logic pr = 1'b0);
      bus(adr(i), 1'b1, d, pr);
   endtask : wr

   task automatic rd(input slcs_idx_t i, input logic [7:0] e, input string nm);
      notes.push_back('{nm, {24'h00_0000, e}});
      bus(adr(i), 1'b0, 8'h00, 1'b0);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      @(negedge hclk);
   endtask : tick

   // One-cycle pulse on the frame-end slot, then the insert flag on both sides.
   task automatic eof_pulse(input logic e);
      @(posedge hclk);
      fes <= 1'b1;
      @(posedge hclk);
      fes <= 1'b0;
      @(negedge hclk);
      cmp_port("comma insert", {7'h00, e}, {7'h00, ins});
      @(negedge hclk);
      cmp_port("comma insert end", 8'h00, {7'h00, ins});
   endtask : eof_pulse

   // ======================================================================
   // Clock, and the monitor that takes the oldest note for each read result.
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_dp <= 1'b0;
      end else begin
         if (rd_dp && hreadyout === 1'b1) begin
            if (notes.size() == 0) begin
               n_errors++;
               $display("[FAIL] read note expected 1 seen 0");
            end else begin
               cur = notes.pop_front();
               cmp_rd(cur.name, cur.exp, hrdata);
               cmp_port("hresp", 8'h00, {7'h00, hresp});
            end
         end
         rd_dp <= hsel & htrans[1] & ~hwrite & hreadyout;
      end
   end

   // ======================================================================
   // Main sequence.
   initial begin
      {hsel, hwrite, link_up, sync_n, ser_lock, smp_lock, realign, sysref} = '0;
      {ila_mf, fes, haddr, hwdata, htrans, lanes_full, conv_full} = '0;
      ce       = 1'b1;
      n_errors = 0;
      checks   = 0;
      hresetn  = 1'b0;
      void'($urandom(73395));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      tick(1);
      cmp_port("eof comma", `SLCS_K28_7, eof_comma);
      cmp_port("chan active", 8'h0F, {4'h0, chan_active});
      cmp_port("irq", 8'h00, {7'h00, irq});
      rd(`SLCS_IDX_DEVICE_ID, 8'h00, "id reset");
      rd(`SLCS_IDX_COMMA_SEL, 8'h00, "comma reset");
      rd(`SLCS_IDX_STATUS, 8'h00, "status reset");
      rd(`SLCS_IDX_CHAN_EN, 8'h03, "chan reset");
      rd(`SLCS_IDX_IRQ_MASK, 8'h00, "mask reset");
      rd(`SLCS_IDX_LINK_CTRL, 8'h00, "ctrl reset");
      wr(12'h20C, 8'hA5);
      rd(12'h20C, 8'h00, "unmapped");
      $display("test reset done");
      // identifier in ILA, written while the link is off.
      r = $urandom;
      wr(`SLCS_IDX_DEVICE_ID, r[7:0]);
      rd(`SLCS_IDX_DEVICE_ID, r[7:0], "id");
      @(posedge hclk);
      ila_mf <= 1'b1;
      @(posedge hclk);
      ila_mf <= 1'b0;
      @(negedge hclk);
      cmp_port("ila octet", r[7:0], ila_octet);
      tick(1);
      cmp_port("ila idle", 8'h00, ila_octet);
      $display("test identifier done");
      // every comma code, then insert only in 8B/10B with the link on.
      for (int i = 0; i < 4; i++) begin
         wr(`SLCS_IDX_COMMA_SEL, i[7:0]);
         rd(`SLCS_IDX_COMMA_SEL, i[7:0], "comma sel");
         tick(1);
         cmp_port("eof comma", commas[i], eof_comma);
      end
      wr(`SLCS_IDX_COMMA_SEL, 8'h02);
      eof_pulse(1'b0);
      wr(`SLCS_IDX_LINK_CTRL, 8'h01);
      eof_pulse(1'b1);
      wr(`SLCS_IDX_LINK_CTRL, 8'h03);
      eof_pulse(1'b0);
      wr(`SLCS_IDX_LINK_CTRL, 8'h00);
      $display("test comma done");
      // live bits follow the inputs and ignore writes.
      repeat (6) begin
         r = $urandom;
         link_up  <= r[0];
         sync_n   <= r[1];
         ser_lock <= r[2];
         smp_lock <= r[3];
         tick(2);
         v = {1'b0, r[0], r[1], 2'b00, r[2], 1'b0, r[3]};
         rd(`SLCS_IDX_STATUS, v, "status live");
         wr(`SLCS_IDX_STATUS, 8'hFF);
         rd(`SLCS_IDX_STATUS, v, "status after write");
      end
      {link_up, sync_n, ser_lock, smp_lock} <= 4'h0;
      $display("test live status done");
      // arming by a link enable rise, sticky flags and the interrupt.
      wr(`SLCS_IDX_LINK_CTRL, 8'h01);
      @(posedge hclk);
      {realign, sysref} <= 2'b11;
      @(posedge hclk);
      {realign, sysref} <= 2'b00;
      rd(`SLCS_IDX_STATUS, 8'h18, "flags set");
      tick(2);
      cmp_port("irq masked", 8'h00, {7'h00, irq});
      wr(`SLCS_IDX_IRQ_MASK, 8'h10);
      tick(2);
      cmp_port("irq unmasked", 8'h01, {7'h00, irq});
      wr(`SLCS_IDX_STATUS, 8'h00);
      rd(`SLCS_IDX_STATUS, 8'h18, "write zero");
      wr(`SLCS_IDX_STATUS, 8'h08);
      @(posedge hclk);
      sysref <= 1'b1;
      @(posedge hclk);
      sysref <= 1'b0;
      rd(`SLCS_IDX_STATUS, 8'h10, "only first sysref");
      wr(`SLCS_IDX_STATUS, 8'h10, 1'b1);
      rd(`SLCS_IDX_STATUS, 8'h10, "set beats clear");
      wr(`SLCS_IDX_STATUS, 8'h10);
      rd(`SLCS_IDX_STATUS, 8'h00, "flag cleared");
      tick(2);
      cmp_port("irq cleared", 8'h00, {7'h00, irq});
      // A realign event while the clock enable is low must leave no trace.
      @(posedge hclk);
      {ce, realign} <= 2'b01;
      @(posedge hclk);
      {ce, realign} <= 2'b10;
      rd(`SLCS_IDX_STATUS, 8'h00, "enable low freezes");
      wr(`SLCS_IDX_LINK_CTRL, 8'h00);
      $display("test flags done");
      // pair enables scale lanes and converters, link held off.
      lf = 1 + ($urandom % 8);
      mf = 2 * (1 + ($urandom % 4));
      lanes_full <= lf[3:0];
      conv_full  <= mf[3:0];
      for (int i = 0; i < 4; i++) begin
         v = chans[i];
         wr(`SLCS_IDX_CHAN_EN, v);
         rd(`SLCS_IDX_CHAN_EN, v, "chan en");
         tick(2);
         half = {7'h00, v[0] ^ v[1]};
         ca   = v[2] ? 8'h01 : {4'h0, v[1], v[1], v[0], v[0]};
         cmp_port("chan active", ca, {4'h0, chan_active});
         cmp_port("lanes", half[0] ? 8'((lf + 1) / 2) : 8'(lf), {4'h0, lanes_used});
         cmp_port("convs", half[0] ? 8'(mf / 2) : 8'(mf), {4'h0, conv_used});
         cmp_port("tail", {7'h00, half[0] & lf[0]}, {7'h00, tail_pad});
      end
      $display("test channels done");
      tick(3);
      cmp_port("notes left", 8'h00, 8'(notes.size()));
      summarize();
   end
endmodule : slcs_bank_tb_top
